// [verilog/pd_tx_param_pkg.sv]
package pd_tx_param_pkg;

   localparam logic [15:0] TRANSMIT_PARAMS_A_ADDR = 16'h1A04;

   // field positions of transmit_params_a
   localparam int WAIT_FOR_ACK_BIT = 7;
   localparam int SOP_SEL_LSB = 4;
   localparam int PERMIT_BIT = 3;
   localparam int MSG_ID_LSB = 0;

   localparam logic RESET_WAIT_FOR_ACK = 1'h0;
   localparam logic [2:0] RESET_SOP_SEL = 3'h0;
   localparam logic RESET_PERMIT = 1'h0;
   localparam logic [2:0] RESET_MSG_ID = 3'h0;

   // ordered-set selector codes, 101 to 111 reserved
   localparam logic [2:0] SOP_PLAIN = 3'h0;
   localparam logic [2:0] SOP_PRIME = 3'h1;
   localparam logic [2:0] SOP_DPRIME = 3'h2;
   localparam logic [2:0] SOP_PRIME_DEBUG = 3'h3;
   localparam logic [2:0] SOP_DPRIME_DEBUG = 3'h4;

   localparam int CLK_HZ = 10_000_000;
   // acknowledge wait window, plain default
   localparam int ACK_WAIT_US = 1000;
   localparam int ACK_WAIT_CYCLES = ACK_WAIT_US * (CLK_HZ / 1_000_000);

   typedef struct packed {
      logic wait_for_ack_flag;
      logic [2:0] ordered_set_selector;
      logic software_transmit_permit;
      logic [2:0] expected_msg_id;
   } transmit_params_a_t;

   typedef struct packed {
      logic [2:0] sop;
      logic [2:0] msg_id;
   } ack_reply_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_SEND = 3'h2,
      ST_WAIT = 3'h4
   } tx_state_t;

endpackage

// [verilog/goodcrc_match.sv]
`timescale 1ns/1ps
module goodcrc_match
   import pd_tx_param_pkg::*;
#(
   parameter int ID_W = 3
) (
   input wire ack_reply_t reply,
   input wire logic [2:0] exp_sop,
   input wire logic [ID_W-1:0] exp_id,
   input wire logic check_sop,
   output logic match
);
   initial begin
      if (ID_W != 3) begin
         $error("goodcrc_match: ID_W must be 3");
      end
   end

   always_comb begin
      match = (reply.msg_id == exp_id) && // R12
         (!check_sop || reply.sop == exp_sop); // R4
   end
endmodule

// [verilog/pd_tx_parameter_control.sv]
// What this block and its software do
// R1 - zero retries plus wait flag: wait for acknowledge before finishing
// R2 - nonzero retries with auto response: always wait, wait flag ignored
// R3 - three-bit selector picks ordered set; codes 101-111 reserved
// R4 - with auto retry, acknowledge ordered set must equal selector
// R5 - software enables receive of chosen ordered set for auto retry
// R6 - permit held zero on received hard/cable reset or receive data
// R7 - software sets permit again for every transmission
// R8 - permit clear aborts software transmissions not yet handed over
// R9 - clearing permit leaves transmission already handed over running
// R10 - permit never blocks transmissions the device issues itself
// R11 - protocol-block reset clears the permit bit
// R12 - acknowledge accepted only when its message id matches expected
// R13 - expected id not inserted in header; software writes it there
// R14 - software zeroes expected id when handling any reset
// R15 - retry limit zero disables hardware retransmission
// R16 - zero retries, flag clear: complete as soon as packet sent
// R17 - mismatching reply counts as no acknowledge: retry or fail
`timescale 1ns/1ps
module pd_tx_parameter_control
   import pd_tx_param_pkg::*;
#(
   parameter int ACK_WAIT_CYC = ACK_WAIT_CYCLES
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic protocol_block_reset,
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr_en,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd_en,
   output logic [7:0] reg_rdata,
   input wire logic [2:0] retry_limit,
   input wire logic auto_response_enable,
   input wire logic rx_hard_reset_seen,
   input wire logic rx_cable_reset_seen,
   input wire logic rx_fifo_not_empty,
   input wire logic sw_tx_req,
   input wire logic hw_tx_req,
   input wire logic tx_sent,
   input wire logic ack_valid,
   input wire ack_reply_t ack_reply,
   output logic tx_start,
   output logic tx_from_sw,
   output logic [2:0] tx_sop_type,
   output logic tx_busy,
   output logic tx_complete,
   output logic tx_acked,
   output logic sw_tx_aborted
);
   initial begin
      if (ACK_WAIT_CYC < 1 || ACK_WAIT_CYC > 65535) begin
         $error("pd_tx_parameter_control: ACK_WAIT_CYC out of range");
      end
   end

   localparam logic [15:0] WAIT_LAST = 16'(ACK_WAIT_CYC - 1);

   transmit_params_a_t param_r;
   tx_state_t state_r;
   logic sw_pend_r;
   logic hw_pend_r;
   logic [2:0] retry_cnt_r;
   logic [15:0] wait_cnt_r;
   logic [7:0] reg_rdata_r;
   logic tx_start_r;
   logic tx_from_sw_r;
   logic tx_busy_r;
   logic tx_complete_r;
   logic tx_acked_r;
   logic sw_abort_r;

   logic permit_hold;
   logic addr_hit;
   logic auto_retry;
   logic need_ack;
   logic retries_left;
   logic reply_match;
   logic no_ack;
   logic sw_start;
   logic hw_start;
   logic sw_kill;

   assign permit_hold = rx_hard_reset_seen || rx_cable_reset_seen ||
      rx_fifo_not_empty; // R6
   assign addr_hit = (reg_addr == TRANSMIT_PARAMS_A_ADDR);
   assign auto_retry = (retry_limit != 3'h0) && auto_response_enable; // R15
   // flag matters only when hardware retry is off
   assign need_ack = auto_retry || param_r.wait_for_ack_flag; // R1 R2
   assign retries_left = auto_retry && (retry_cnt_r < retry_limit);
   assign hw_start = (state_r == ST_IDLE) && hw_pend_r; // R10
   assign sw_kill = sw_pend_r && !param_r.software_transmit_permit; // R8
   assign sw_start = (state_r == ST_IDLE) && !hw_pend_r && sw_pend_r &&
      param_r.software_transmit_permit;
   assign no_ack = (state_r == ST_WAIT) && ((ack_valid && !reply_match) ||
      (!ack_valid && wait_cnt_r == WAIT_LAST)); // R17

   goodcrc_match #(
      .ID_W(3)
   ) u_match (
      .reply(ack_reply),
      .exp_sop(param_r.ordered_set_selector),
      .exp_id(param_r.expected_msg_id),
      .check_sop(auto_retry),
      .match(reply_match)
   );

   // expected id never reaches the header path, software owns it there
   // one process for the whole register keeps a single driver
   // hardware hold beats a software set in the same cycle
   always_ff @(posedge mclk or negedge rst_n) begin // R13
      if (!rst_n) begin
         param_r.wait_for_ack_flag <= RESET_WAIT_FOR_ACK;
         param_r.ordered_set_selector <= RESET_SOP_SEL;
         param_r.software_transmit_permit <= RESET_PERMIT;
         param_r.expected_msg_id <= RESET_MSG_ID; // R12
      end else begin
         if (reg_wr_en && addr_hit) begin
            param_r.wait_for_ack_flag <= reg_wdata[WAIT_FOR_ACK_BIT];
            param_r.ordered_set_selector <= reg_wdata[SOP_SEL_LSB +: 3]; // R3
            param_r.expected_msg_id <= reg_wdata[MSG_ID_LSB +: 3];
         end
         if (protocol_block_reset) begin
            param_r.software_transmit_permit <= 1'b0; // R11
         end else if (permit_hold) begin
            param_r.software_transmit_permit <= 1'b0; // R6
         end else if (reg_wr_en && addr_hit) begin
            param_r.software_transmit_permit <= reg_wdata[PERMIT_BIT]; // R7
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_r <= 8'h00;
      end else if (reg_rd_en) begin
         reg_rdata_r <= addr_hit ? param_r : 8'h00;
      end
   end

   // a new request in the clearing cycle wins
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sw_pend_r <= 1'b0;
         hw_pend_r <= 1'b0;
         sw_abort_r <= 1'b0;
      end else begin
         sw_abort_r <= sw_kill && !sw_tx_req; // R8
         if (sw_tx_req) begin
            sw_pend_r <= 1'b1;
         end else if (sw_start || sw_kill || protocol_block_reset) begin
            sw_pend_r <= 1'b0;
         end
         if (hw_tx_req) begin
            hw_pend_r <= 1'b1;
         end else if (hw_start || protocol_block_reset) begin
            hw_pend_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
         retry_cnt_r <= 3'h0;
         wait_cnt_r <= 16'h0000;
         tx_start_r <= 1'b0;
         tx_from_sw_r <= 1'b0;
         tx_complete_r <= 1'b0;
         tx_acked_r <= 1'b0;
      end else begin
         tx_start_r <= 1'b0;
         tx_complete_r <= 1'b0;
         tx_acked_r <= 1'b0;
         if (protocol_block_reset) begin
            state_r <= ST_IDLE;
         end else begin
            unique case (state_r)
               ST_IDLE: begin
                  if (hw_start || sw_start) begin
                     state_r <= ST_SEND;
                     tx_start_r <= 1'b1;
                     tx_from_sw_r <= !hw_start;
                     retry_cnt_r <= 3'h0;
                  end
               end
               // permit no longer consulted once handed over
               ST_SEND: begin // R9
                  if (tx_sent) begin
                     wait_cnt_r <= 16'h0000;
                     if (need_ack) begin
                        state_r <= ST_WAIT; // R1 R2
                     end else begin
                        state_r <= ST_IDLE;
                        tx_complete_r <= 1'b1; // R16
                     end
                  end
               end
               ST_WAIT: begin
                  wait_cnt_r <= wait_cnt_r + 16'h0001;
                  if (ack_valid && reply_match) begin
                     state_r <= ST_IDLE;
                     tx_complete_r <= 1'b1;
                     tx_acked_r <= 1'b1; // R12 R4
                  end else if (no_ack && retries_left) begin
                     state_r <= ST_SEND; // R17
                     tx_start_r <= 1'b1;
                     retry_cnt_r <= retry_cnt_r + 3'h1;
                  end else if (no_ack) begin
                     state_r <= ST_IDLE; // R15
                     tx_complete_r <= 1'b1;
                  end
               end
               default: state_r <= ST_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tx_busy_r <= 1'b0;
      end else begin
         tx_busy_r <= (state_r != ST_IDLE);
      end
   end

   assign reg_rdata = reg_rdata_r;
   assign tx_start = tx_start_r;
   assign tx_from_sw = tx_from_sw_r;
   assign tx_sop_type = param_r.ordered_set_selector; // R3
   assign tx_busy = tx_busy_r;
   assign tx_complete = tx_complete_r;
   assign tx_acked = tx_acked_r;
   assign sw_tx_aborted = sw_abort_r;

   AST_PERMIT_HELD: assert property ( // R6
      @(posedge mclk) disable iff (!rst_n)
      permit_hold |=> !param_r.software_transmit_permit)
      else $error("permit not held clear during receive events");

   AST_PROTOCOL_BLOCK_RESET_CLEARS: assert property ( // R11
      @(posedge mclk) disable iff (!rst_n)
      protocol_block_reset |=> !param_r.software_transmit_permit [*1]
      ##0 (state_r == ST_IDLE))
      else $error("protocol reset did not clear permit");

   AST_SW_ABORT: assert property ( // R8
      @(posedge mclk) disable iff (!rst_n)
      (sw_pend_r && !param_r.software_transmit_permit && !sw_tx_req)
      |=> sw_tx_aborted && !sw_pend_r &&
      !(tx_start && tx_from_sw && !tx_busy))
      else $error("unpermitted software request not aborted");

   AST_HW_NOT_BLOCKED: assert property ( // R10
      @(posedge mclk) disable iff (!rst_n)
      (state_r == ST_IDLE && hw_pend_r && !protocol_block_reset)
      |=> tx_start && !tx_from_sw ##1 tx_busy)
      else $error("device transmission not started");

   AST_SEND_KEEPS: assert property ( // R9
      @(posedge mclk) disable iff (!rst_n)
      (state_r == ST_SEND && !tx_sent && !protocol_block_reset)
      |=> state_r == ST_SEND)
      else $error("handed transmission dropped");

   AST_NO_WAIT: assert property ( // R16
      @(posedge mclk) disable iff (!rst_n)
      (state_r == ST_SEND && tx_sent && !need_ack && !protocol_block_reset)
      |=> tx_complete && !tx_acked && state_r == ST_IDLE)
      else $error("no-wait transmission not completed at once");

   AST_WAITS: assert property ( // R1
      @(posedge mclk) disable iff (!rst_n)
      (state_r == ST_SEND && tx_sent && need_ack && !protocol_block_reset)
      |=> state_r == ST_WAIT && !tx_complete)
      else $error("acknowledge wait skipped");

   AST_ACK_MATCH: assert property ( // R12
      @(posedge mclk) disable iff (!rst_n)
      tx_acked |-> $past(ack_reply.msg_id) == $past(param_r.expected_msg_id)
      && $past(ack_valid))
      else $error("acknowledge accepted with wrong message id");

   AST_RETRY_ON_MISMATCH: assert property ( // R17
      @(posedge mclk) disable iff (!rst_n)
      (state_r == ST_WAIT && ack_valid && !reply_match && retries_left &&
      !protocol_block_reset) |=> tx_start && state_r == ST_SEND)
      else $error("mismatching reply did not retry");

   AST_NO_RETRY_ZERO: assert property ( // R15
      @(posedge mclk) disable iff (!rst_n)
      (retry_limit == 3'h0 && no_ack && !protocol_block_reset)
      |=> tx_complete && !tx_acked && !tx_start)
      else $error("retry issued with zero retry limit");

   AST_AUTO_WAITS: assert property ( // R2
      @(posedge mclk) disable iff (!rst_n)
      (state_r == ST_SEND && tx_sent && retry_limit != 3'h0 &&
      auto_response_enable && !protocol_block_reset)
      |=> state_r == ST_WAIT && !tx_complete)
      else $error("automatic retry mode did not wait for acknowledge");

   AST_ACK_SOP: assert property ( // R4
      @(posedge mclk) disable iff (!rst_n)
      (state_r == ST_WAIT && ack_valid && retry_limit != 3'h0 &&
      auto_response_enable && ack_reply.sop != param_r.ordered_set_selector)
      |=> !tx_acked)
      else $error("acknowledge accepted with wrong ordered set");

endmodule

// [sim/pd_port_partner.sv]
`timescale 1ns/1ps
module pd_port_partner
   import pd_tx_param_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic tx_start,
   input wire logic rep_en,
   input wire logic [3:0] lag,
   input wire ack_reply_t rep,
   output logic tx_sent,
   output logic ack_valid,
   output ack_reply_t ack_reply
);
   int cnt;
   // packet takes four cycles; reply comes lag plus one cycles after tx_sent
   // every start restarts the packet, so retries are answered too
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 0;
         tx_sent <= 1'b0;
         ack_valid <= 1'b0;
         ack_reply <= '0;
      end else begin
         tx_sent <= (cnt == 4);
         ack_valid <= rep_en && (cnt == 5 + lag);
         // reply lines toggle outside the reply, so stale data equals the reply only on alternate cycles
         ack_reply <= (cnt == 5 + lag) ? rep : ~ack_reply;
         if (tx_start)
            cnt <= 1;
         else if (cnt != 0 && cnt < 24)
            cnt <= cnt + 1;
         else
            cnt <= 0;
      end
   end
endmodule

// [sim/pd_tx_parameter_control_test.sv]
`timescale 1ns/1ps
module pd_tx_parameter_control_test;
   import pd_tx_param_pkg::*;
   localparam logic [15:0] A = TRANSMIT_PARAMS_A_ADDR;
   logic mclk = 1'b0, rst_n = 1'b0, pbr = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wd = 8'h00, rdata;
   logic [2:0] rl = 3'h0, hold = 3'h0, sopt;
   logic au = 1'b0, swq = 1'b0, hwq = 1'b0, rep_en = 1'b0;
   logic [3:0] lag = 4'h2;
   ack_reply_t rep = '0, ar;
   logic tst, tfs, busy, cmpl, ackd, abt, sent, av;
   int n_mismatch = 0, n_checks = 0, n_st = 0, seed = 51;

   pd_tx_parameter_control #(.ACK_WAIT_CYC(20)) i_dut (.mclk(mclk),
      .rst_n(rst_n), .protocol_block_reset(pbr), .reg_addr(addr),
      .reg_wr_en(wr), .reg_wdata(wd), .reg_rd_en(rd), .reg_rdata(rdata),
      .retry_limit(rl), .auto_response_enable(au),
      .rx_hard_reset_seen(hold[2]), .rx_cable_reset_seen(hold[1]),
      .rx_fifo_not_empty(hold[0]), .sw_tx_req(swq), .hw_tx_req(hwq),
      .tx_sent(sent), .ack_valid(av), .ack_reply(ar), .tx_start(tst),
      .tx_from_sw(tfs), .tx_sop_type(sopt), .tx_busy(busy),
      .tx_complete(cmpl), .tx_acked(ackd), .sw_tx_aborted(abt));
   pd_port_partner i_far (.mclk(mclk), .rst_n(rst_n), .tx_start(tst),
      .rep_en(rep_en), .lag(lag), .rep(rep), .tx_sent(sent),
      .ack_valid(av), .ack_reply(ar));

   always #50 mclk = ~mclk;
   always @(posedge mclk) if (tst === 1'b1) n_st <= n_st + 1;

   task chk(input logic ok, input string m);
      n_checks++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("MISMATCH at %0t: %s", $time, m);
      end
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task wr8(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task rd8(input logic [15:0] a, input logic [7:0] e);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      chk(rdata === e, "read data");
      @(posedge mclk);
   endtask
   task cfg(input logic [2:0] r, input logic a, input logic [7:0] d,
            input logic e, input ack_reply_t p);
      rl <= r;
      au <= a;
      rep_en <= e;
      rep <= p;
      lag <= 4'($random(seed) & 7);
      wr8(A, d);
   endtask
   // starts per transmission: first send plus one per allowed retry
   function automatic int exp_starts(input logic [2:0] r, input logic a,
                                     input logic ok);
      return (r != 3'h0 && a && !ok) ? 1 + int'(r) : 1;
   endfunction
   // late: receive data arrives after hand-over, must not stop it
   task automatic tx(input logic sw, ab, ak, input int ns, input logic late);
      int n = 0;
      int s0 = n_st;
      logic hit;
      @(posedge mclk);
      swq <= sw;
      hwq <= !sw;
      @(posedge mclk);
      swq <= 1'b0;
      hwq <= 1'b0;
      @(negedge mclk);
      while (cmpl !== 1'b1 && abt !== 1'b1 && n < 400) begin
         hit = late && tst === 1'b1;
         @(posedge mclk);
         if (hit) hold[0] <= 1'b1;
         @(negedge mclk);
         n++;
      end
      chk(abt === ab && ackd === ak, "outcome");
      chk(n_st - s0 == ns, "start count");
      chk(busy === !ab, "busy at end");
      if (!ab) chk(tfs === sw, "source");
      @(posedge mclk);
      hold[0] <= 1'b0;
      @(negedge mclk);
      chk(busy === 1'b0, "busy after end");
      @(posedge mclk);
   endtask

   initial begin
      logic [7:0] d;
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      rd8(A, 8'h00);
      for (int c = 0; c < 8; c++) begin
         d = 8'($random(seed));
         d[6:4] = c[2:0];
         wr8(A, d);
         rd8(A, d);
         chk(sopt === c[2:0], "selector");
      end
      wr8(16'h1A05, 8'hFF);
      rd8(A, d);
      rd8(16'h1A05, 8'h00);
      for (int i = 0; i < 3; i++) begin
         wr8(A, 8'h08);
         rd8(A, 8'h08);
         hold <= 3'h1 << i;
         rd8(A, 8'h00);
         wr8(A, 8'h08);
         rd8(A, 8'h00);
         hold <= 3'h0;
      end
      wr8(A, 8'hB8);
      @(posedge mclk);
      pbr <= 1'b1;
      @(posedge mclk);
      pbr <= 1'b0;
      rd8(A, 8'hB0);
      wr8(A, 8'h30);
      cfg(3'h0, 1'b0, 8'h25, 1'b1, {3'h2, 3'h5});
      tx(1'b1, 1'b1, 1'b0, 0, 1'b0);
      tx(1'b0, 1'b0, 1'b0, 1, 1'b0);
      d = 8'($random(seed));
      cfg(3'h0, 1'b0, {5'h15, d[2:0]}, 1'b1, {3'h2, d[2:0]});
      tx(1'b1, 1'b0, 1'b1, 1, 1'b1);
      cfg(3'h0, 1'b0, 8'hAD, 1'b1, {3'h2, 3'h4});
      tx(1'b1, 1'b0, 1'b0, 1, 1'b0);
      cfg(3'h0, 1'b0, 8'hAD, 1'b1, {3'h3, 3'h5});
      tx(1'b1, 1'b0, 1'b1, 1, 1'b0);
      cfg(3'h3, 1'b0, 8'h2D, 1'b1, {3'h2, 3'h5});
      tx(1'b1, 1'b0, 1'b0, 1, 1'b0);
      cfg(3'h2, 1'b1, 8'h2D, 1'b1, {3'h3, 3'h5});
      tx(1'b1, 1'b0, 1'b0, exp_starts(3'h2, 1'b1, 1'b0), 1'b0);
      cfg(3'h2, 1'b1, 8'h2D, 1'b1, {3'h2, 3'h5});
      tx(1'b1, 1'b0, 1'b1, exp_starts(3'h2, 1'b1, 1'b1), 1'b0);
      cfg(3'h2, 1'b1, 8'h2D, 1'b0, {3'h2, 3'h5});
      tx(1'b0, 1'b0, 1'b0, exp_starts(3'h2, 1'b1, 1'b0), 1'b0);
      finish_test;
   end

   initial begin
      #3000000;
      n_mismatch++;
      $display("MISMATCH at %0t: timeout", $time);
      finish_test;
   end
endmodule
